// *** hdl/ccc_cmd_decode.sv ***
// Decoder from a command word to one flag per command other than the null command.
`timescale 1ns/1ps
module ccc_cmd_decode
  import ccc_pkg::*;
(
  // Command word in.
  input  wire logic [31:0] i_word,
  // One flag per command other than the null command.
  output ccc_cmd_s         o_cmd
);
  always_comb begin
    o_cmd = '0;
    if (i_word[31:CMD_CODE_W] == '0) begin
      case (i_word[CMD_CODE_W-1:0])
        CODE_WRITE_FRAMES_CMD:     o_cmd.write_frames  = 1'b1;
        CODE_MFW:      o_cmd.multi_frame   = 1'b1;
        CODE_RELEASE:  o_cmd.release_hold  = 1'b1;
        CODE_READ_FRAMES_CMD:     o_cmd.read_frames   = 1'b1;
        CODE_START:    o_cmd.start         = 1'b1;
        CODE_CAPCLR:   o_cmd.capture_clear = 1'b1;
        CODE_CRCRST:   o_cmd.crc_reset     = 1'b1;
        CODE_ISOLATE:  o_cmd.isolate       = 1'b1;
        CODE_SWITCH:   o_cmd.clk_switch    = 1'b1;
        CODE_RESTORE:  o_cmd.restore       = 1'b1;
        CODE_SHUTDOWN: o_cmd.shutdown      = 1'b1;
        CODE_CAPTURE:  o_cmd.capture       = 1'b1;
        CODE_DESYNC:   o_cmd.desync        = 1'b1;
        CODE_WARMBOOT: o_cmd.warm_boot     = 1'b1;
        CODE_RECALC:   o_cmd.recalc        = 1'b1;
        CODE_WDRELOAD: o_cmd.wd_reload     = 1'b1;
        default:       o_cmd = '0;
      endcase
    end
  end
endmodule : ccc_cmd_decode

// *** hdl/ccc_mask_merge.sv ***
// Bit-masked merge of a new control word into the held one.
`timescale 1ns/1ps
module ccc_mask_merge
  import ccc_pkg::*;
(
  // Held value, written value and mask.
  input  wire logic [31:0] i_old,
  input  wire logic [31:0] i_new,
  input  wire logic [31:0] i_mask,
  // Merged value.
  output logic [31:0]      o_val
);
  assign o_val = ((i_old & ~i_mask) | (i_new & i_mask)) & CONTROL_ZERO_REG_WRITABLE;
endmodule : ccc_mask_merge

// *** hdl/ccc_pkg.sv ***
// Constants and types shared by the configuration command block.
package ccc_pkg;
  localparam int          CMD_CODE_W = 5;
  localparam logic [4:0]  ADDR_CRC   = 5'h00;
  localparam logic [4:0]  ADDR_FAR   = 5'h01;
  localparam logic [4:0]  ADDR_CMD   = 5'h04;
  localparam logic [4:0]  ADDR_CONTROL_ZERO_REG  = 5'h05;
  localparam logic [4:0]  ADDR_MASK  = 5'h06;
  localparam logic [4:0]  ADDR_OPTION_REG_ZERO  = 5'h09;
  localparam logic [4:0]  CODE_NULL     = 5'h00;
  localparam logic [4:0]  CODE_WRITE_FRAMES_CMD     = 5'h01;
  localparam logic [4:0]  CODE_MFW      = 5'h02;
  localparam logic [4:0]  CODE_RELEASE  = 5'h03;
  localparam logic [4:0]  CODE_READ_FRAMES_CMD     = 5'h04;
  localparam logic [4:0]  CODE_START    = 5'h05;
  localparam logic [4:0]  CODE_CAPCLR   = 5'h06;
  localparam logic [4:0]  CODE_CRCRST   = 5'h07;
  localparam logic [4:0]  CODE_ISOLATE  = 5'h08;
  localparam logic [4:0]  CODE_SWITCH   = 5'h09;
  localparam logic [4:0]  CODE_RESTORE  = 5'h0A;
  localparam logic [4:0]  CODE_SHUTDOWN = 5'h0B;
  localparam logic [4:0]  CODE_CAPTURE  = 5'h0C;
  localparam logic [4:0]  CODE_DESYNC   = 5'h0D;
  localparam logic [4:0]  CODE_WARMBOOT = 5'h0F;
  localparam logic [4:0]  CODE_RECALC   = 5'h10;
  localparam logic [4:0]  CODE_WDRELOAD = 5'h11;
  localparam int          CONTROL_ZERO_REG_PORT_SEL   = 30;
  localparam int          CONTROL_ZERO_REG_THERMAL    = 12;
  localparam int          CONTROL_ZERO_REG_NOFALLBACK = 10;
  localparam int          CONTROL_ZERO_REG_ABORT_DIS  = 9;
  localparam int          CONTROL_ZERO_REG_LUTMASK_N  = 8;
  localparam int          CONTROL_ZERO_REG_AES_ON     = 6;
  localparam int          CONTROL_ZERO_REG_SEC_HI     = 5;
  localparam int          CONTROL_ZERO_REG_SEC_LO     = 4;
  localparam int          CONTROL_ZERO_REG_KEEP_PORT  = 3;
  localparam int          CONTROL_ZERO_REG_USER_TS_N  = 0;
  localparam logic [31:0] CONTROL_ZERO_REG_RESET      = 32'h0000_0101;
  localparam logic [31:0] CONTROL_ZERO_REG_WRITABLE   = 32'h4000_1779;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
  localparam int          OUTPUT_FREQ_SELECT_LSB       = 17;
  localparam int          OUTPUT_FREQ_SELECT_W         = 6;

  typedef struct packed {
    logic write_frames;
    logic multi_frame;
    logic release_hold;
    logic read_frames;
    logic start;
    logic capture_clear;
    logic crc_reset;
    logic isolate;
    logic clk_switch;
    logic restore;
    logic shutdown;
    logic capture;
    logic desync;
    logic warm_boot;
    logic recalc;
    logic wd_reload;
  } ccc_cmd_s;

  typedef enum logic [2:0] {
    FA_IDLE  = 3'b001,
    FA_WRITE = 3'b010,
    FA_READ  = 3'b100
  } ccc_frame_e;
endpackage : ccc_pkg

// *** hdl/ccc_top.sv ***
// Configuration command interpreter and first control register.
`timescale 1ns/1ps
module ccc_top
  import ccc_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // Register port from the packet processor.
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  input  wire logic [4:0]          i_reg_addr,
  input  wire logic [31:0]         i_reg_wdata,
  output logic [31:0]              o_reg_rdata,
  // Status from the surrounding configuration logic.
  input  wire logic                i_sync_found,
  input  wire logic [31:0]         i_crc_calc,
  input  wire logic                i_readback_crc_en,
  input  wire logic                i_config_io_tristate_n,
  input  wire logic                i_config_done,
  // Frame access and command strobes.
  output logic                     o_write_armed,
  output logic                     o_read_armed,
  output logic                     o_multi_frame_write,
  output logic                     o_interconnect_hold_n,
  output logic                     o_startup_go,
  output logic                     o_capture_pulse,
  output logic                     o_capture_held,
  output logic                     o_crc_reset,
  output logic                     o_crc_error,
  output logic                     o_clk_switch,
  output logic [OUTPUT_FREQ_SELECT_W-1:0]       o_clk_freq_sel,
  output logic                     o_restore_pulse,
  output logic                     o_shutdown_active,
  output logic                     o_word_aligned,
  output logic                     o_readback_recalc,
  output logic                     o_warm_boot,
  output logic                     o_watchdog_reload,
  output logic [31:0]              o_frame_location,
  // Control register fields.
  output logic                     o_port_bottom,
  output logic [1:0]               o_security_level,
  output logic                     o_readback_allowed,
  output logic                     o_write_allowed,
  output logic                     o_config_port_active,
  output logic                     o_user_io_tristate_n,
  output logic                     o_user_pullup_off,
  output logic                     o_no_fallback_on_fail,
  output logic                     o_parallel_abort_disable,
  output logic                     o_lut_readback_mask_n,
  output logic                     o_aes_unit_on,
  output logic                     o_thermal_shutoff_enable
);
  logic [31:0] cmd_word;
  logic [31:0] mask;
  logic [31:0] option_reg_zero;
  logic [31:0] control_zero_reg;
  logic [31:0] next_control_zero_reg;
  logic [31:0] exec_word;
  logic        wr_ok;
  logic        cmd_wr;
  logic        far_wr;
  logic        crc_wr;
  logic        crc_match;
  logic        exec;
  logic        start_pending;
  logic        desynced;
  logic        crc_good;
  logic        shutdown_armed;
  ccc_cmd_s    dec_cmd;
  ccc_cmd_s    hit;
  ccc_frame_e  frame_state;

  // Register writes count only while the data stream is aligned.
  assign wr_ok     = i_reg_wr & o_word_aligned;
  assign cmd_wr    = wr_ok & (i_reg_addr == ADDR_CMD);
  assign far_wr    = wr_ok & (i_reg_addr == ADDR_FAR);
  assign crc_wr    = wr_ok & (i_reg_addr == ADDR_CRC);
  assign crc_match = crc_wr & (i_reg_wdata == i_crc_calc);
  assign exec      = cmd_wr | far_wr;
  assign exec_word = cmd_wr ? i_reg_wdata : cmd_word;
  assign hit       = exec ? dec_cmd : '0;

  ccc_cmd_decode u_decode (
    .i_word (exec_word),
    .o_cmd  (dec_cmd)
  );

  ccc_mask_merge u_merge (
    .i_old  (control_zero_reg),
    .i_new  (i_reg_wdata),
    .i_mask (mask),
    .o_val  (next_control_zero_reg)
  );

  // Stored registers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_word         <= WORD_RESET;
      mask             <= MASK_RESET;
      option_reg_zero             <= WORD_RESET;
      o_frame_location <= WORD_RESET;
    end else if (i_ce) begin
      if (cmd_wr) begin
        cmd_word <= i_reg_wdata;
      end
      if (far_wr) begin
        o_frame_location <= i_reg_wdata;
      end
      if (wr_ok && i_reg_addr == ADDR_MASK) begin
        mask <= i_reg_wdata;
      end
      if (wr_ok && i_reg_addr == ADDR_OPTION_REG_ZERO) begin
        option_reg_zero <= i_reg_wdata;
      end
    end
  end

  // First control register with masked writes.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      control_zero_reg <= CONTROL_ZERO_REG_RESET;
    end else if (i_ce && wr_ok && i_reg_addr == ADDR_CONTROL_ZERO_REG) begin
      control_zero_reg <= next_control_zero_reg;
    end
  end

  assign o_port_bottom            = control_zero_reg[CONTROL_ZERO_REG_PORT_SEL];
  assign o_security_level         = control_zero_reg[CONTROL_ZERO_REG_SEC_HI:CONTROL_ZERO_REG_SEC_LO];
  assign o_user_io_tristate_n     = control_zero_reg[CONTROL_ZERO_REG_USER_TS_N];
  assign o_no_fallback_on_fail    = control_zero_reg[CONTROL_ZERO_REG_NOFALLBACK];
  assign o_parallel_abort_disable = control_zero_reg[CONTROL_ZERO_REG_ABORT_DIS];
  assign o_lut_readback_mask_n    = control_zero_reg[CONTROL_ZERO_REG_LUTMASK_N];
  assign o_aes_unit_on            = control_zero_reg[CONTROL_ZERO_REG_AES_ON];
  assign o_thermal_shutoff_enable = control_zero_reg[CONTROL_ZERO_REG_THERMAL];

  // Derived control levels.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readback_allowed   <= 1'b1;
      o_write_allowed      <= 1'b1;
      o_config_port_active <= 1'b1;
      o_user_pullup_off    <= 1'b0;
    end else if (i_ce) begin
      o_readback_allowed   <= (control_zero_reg[CONTROL_ZERO_REG_SEC_HI:CONTROL_ZERO_REG_SEC_LO] == 2'b00);
      o_write_allowed      <= ~control_zero_reg[CONTROL_ZERO_REG_SEC_HI];
      o_config_port_active <= control_zero_reg[CONTROL_ZERO_REG_KEEP_PORT] | ~i_config_done;
      o_user_pullup_off    <= ~control_zero_reg[CONTROL_ZERO_REG_USER_TS_N] &
                              ~i_config_io_tristate_n;
    end
  end

  // Frame access mode, gated by the security level.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_state <= FA_IDLE;
    end else if (i_ce) begin
      case (frame_state)
        FA_IDLE, FA_WRITE, FA_READ: begin
          if (hit.write_frames && !control_zero_reg[CONTROL_ZERO_REG_SEC_HI]) begin
            frame_state <= FA_WRITE;
          end else if (hit.read_frames &&
                       control_zero_reg[CONTROL_ZERO_REG_SEC_HI:CONTROL_ZERO_REG_SEC_LO] == 2'b00) begin
            frame_state <= FA_READ;
          end else if (hit.write_frames || hit.read_frames ||
                       hit.desync) begin
            frame_state <= FA_IDLE;
          end
        end
        default: frame_state <= FA_IDLE;
      endcase
    end
  end

  assign o_write_armed = frame_state[1];
  assign o_read_armed  = frame_state[2];

  // Word alignment.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_word_aligned <= 1'b0;
    end else if (i_ce) begin
      if (i_sync_found) begin
        o_word_aligned <= 1'b1;
      end else if (hit.desync) begin
        o_word_aligned <= 1'b0;
      end
    end
  end

  // Interconnect hold.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_interconnect_hold_n <= 1'b1;
    end else if (i_ce) begin
      if (hit.isolate) begin
        o_interconnect_hold_n <= 1'b0;
      end else if (hit.release_hold) begin
        o_interconnect_hold_n <= 1'b1;
      end
    end
  end

  // CRC check and error flag.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crc_error <= 1'b0;
      crc_good    <= 1'b0;
    end else if (i_ce) begin
      if (crc_wr) begin
        o_crc_error <= ~crc_match;
        crc_good    <= crc_match;
      end else if (hit.crc_reset) begin
        crc_good <= 1'b0;
      end
    end
  end

  // Startup gating.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      start_pending <= 1'b0;
      desynced      <= 1'b0;
      o_startup_go  <= 1'b0;
    end else if (i_ce) begin
      o_startup_go <= start_pending & desynced & crc_good &
                      ~o_startup_go;
      if (hit.start) begin
        start_pending <= 1'b1;
      end else if (o_startup_go) begin
        start_pending <= 1'b0;
      end
      if (hit.desync) begin
        desynced <= 1'b1;
      end else if (o_startup_go) begin
        desynced <= 1'b0;
      end
    end
  end

  // Shutdown arming.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shutdown_armed    <= 1'b0;
      o_shutdown_active <= 1'b0;
    end else if (i_ce) begin
      if (shutdown_armed && (crc_match || hit.crc_reset)) begin
        o_shutdown_active <= 1'b1;
        shutdown_armed    <= 1'b0;
      end else if (hit.shutdown) begin
        shutdown_armed <= 1'b1;
      end
    end
  end

  // Capture level.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture_held <= 1'b0;
    end else if (i_ce) begin
      if (hit.capture) begin
        o_capture_held <= 1'b1;
      end else if (hit.capture_clear) begin
        o_capture_held <= 1'b0;
      end
    end
  end

  // One-cycle command strobes and clock rate.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_multi_frame_write <= 1'b0;
      o_capture_pulse     <= 1'b0;
      o_crc_reset         <= 1'b0;
      o_clk_switch        <= 1'b0;
      o_clk_freq_sel      <= '0;
      o_restore_pulse     <= 1'b0;
      o_readback_recalc   <= 1'b0;
      o_warm_boot         <= 1'b0;
      o_watchdog_reload   <= 1'b0;
    end else if (i_ce) begin
      o_multi_frame_write <= hit.multi_frame;
      o_capture_pulse     <= hit.capture;
      o_crc_reset         <= hit.crc_reset;
      o_clk_switch        <= hit.clk_switch;
      o_restore_pulse     <= hit.restore;
      o_readback_recalc   <= hit.recalc & i_readback_crc_en;
      o_warm_boot         <= hit.warm_boot;
      o_watchdog_reload   <= hit.wd_reload;
      if (hit.clk_switch) begin
        o_clk_freq_sel <= option_reg_zero[OUTPUT_FREQ_SELECT_LSB +: OUTPUT_FREQ_SELECT_W];
      end
    end
  end

  // Register reads.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= WORD_RESET;
    end else if (i_ce && i_reg_rd) begin
      case (i_reg_addr)
        ADDR_CRC:  o_reg_rdata <= i_crc_calc;
        ADDR_FAR:  o_reg_rdata <= o_frame_location;
        ADDR_CMD:  o_reg_rdata <= cmd_word;
        ADDR_CONTROL_ZERO_REG: o_reg_rdata <= control_zero_reg;
        ADDR_MASK: o_reg_rdata <= mask;
        ADDR_OPTION_REG_ZERO: o_reg_rdata <= option_reg_zero;
        default:   o_reg_rdata <= WORD_RESET;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_far_exec: assert property (i_ce && far_wr && !cmd_wr &&
      cmd_word == {27'h0, CODE_RECALC} && i_readback_crc_en |=>
      o_readback_recalc)
    else $error("Frame location write did not rerun the held command");
  a_upper_zero: assert property (i_ce && cmd_wr &&
      i_reg_wdata[31:5] != '0 |=> !o_warm_boot && !o_crc_reset)
    else $error("Command with upper bits set was executed");
  a_write_arm: assert property (i_ce && hit.write_frames &&
      !control_zero_reg[CONTROL_ZERO_REG_SEC_HI] |=> o_write_armed && !o_read_armed)
    else $error("Frame write not armed");
  a_hold_isolate: assert property (i_ce && hit.isolate |=>
      !o_interconnect_hold_n)
    else $error("Interconnect not isolated");
  a_startup_gate: assert property ($rose(o_startup_go) |->
      $past(start_pending) && $past(desynced) && $past(crc_good))
    else $error("Startup began without its preconditions");
  a_crc_rst: assert property (i_ce && hit.crc_reset |=>
      o_crc_reset ##1 (!o_crc_reset || !$past(i_ce) ||
      $past(hit.crc_reset)))
    else $error("CRC reset strobe wrong");
  a_mask_keep: assert property (i_ce && wr_ok &&
      i_reg_addr == ADDR_CONTROL_ZERO_REG && !mask[CONTROL_ZERO_REG_KEEP_PORT] |=>
      $stable(control_zero_reg[CONTROL_ZERO_REG_KEEP_PORT]))
    else $error("Masked control bit changed");
  a_read_block: assert property (i_ce && hit.read_frames &&
      control_zero_reg[CONTROL_ZERO_REG_SEC_HI:CONTROL_ZERO_REG_SEC_LO] != 2'b00 |=> !o_read_armed)
    else $error("Readback armed under security");
  a_desync_drop: assert property (i_ce && hit.desync &&
      !i_sync_found |=> !o_word_aligned)
    else $error("Alignment kept after desync");
  a_crc_clear: assert property (i_ce && crc_match |=>
      !o_crc_error && crc_good)
    else $error("Matching CRC did not clear error");

  c_startup: cover property (o_startup_go);
  c_shutdown: cover property ($rose(o_shutdown_active));
  c_readback: cover property ($rose(o_read_armed));
  c_far_rerun: cover property (far_wr && dec_cmd.write_frames);
endmodule : ccc_top

// *** sim/ccc_crc_model.sv ***
// Running checksum model standing in for the configuration data path.
`timescale 1ns/1ps
module ccc_crc_model
  import ccc_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register writes seen by the block.
  input  wire logic        i_wr,
  input  wire logic [4:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_crc_reset,
  // Running checksum.
  output logic [31:0]      o_crc
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crc <= WORD_RESET;
    end else if (i_crc_reset) begin
      o_crc <= WORD_RESET;
    end else if (i_wr && i_addr != ADDR_CRC) begin
      o_crc <= {o_crc[30:0], o_crc[31]} ^ i_wdata;
    end
  end
endmodule : ccc_crc_model

// *** sim/testbench.sv ***
// Self-checking bench for the configuration command block.
`timescale 1ns/1ps
module testbench;
  import ccc_pkg::*;
  logic        clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, sync = 0;
  logic        rben = 1, ctsn = 1, done = 0;
  logic [4:0]  addr = 0;
  logic [31:0] wd = 0, rdat, crc, floc;
  logic        wa, ra, multi_frame_write_cmd, hn, sgo, cap, caph, crst, cerr, sw, rest;
  logic        shd, alg, rcl, wb, wdr, pb, rba, wra, cpa, utn, puo;
  logic        nfb, pad, lmn, aes, thm;
  logic [5:0]  fsel;
  logic [1:0]  sec;
  logic [7:0]  pv;
  int          n_errors = 0;
  int          n_compared = 0;
  assign pv = {multi_frame_write_cmd, cap, crst, sw, rest, wb, wdr, rcl};
  always #4 clk = ~clk;
  ccc_top dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .i_sync_found(sync), .i_crc_calc(crc), .i_readback_crc_en(rben),
    .i_config_io_tristate_n(ctsn), .i_config_done(done),
    .o_write_armed(wa), .o_read_armed(ra), .o_multi_frame_write(multi_frame_write_cmd),
    .o_interconnect_hold_n(hn), .o_startup_go(sgo), .o_capture_pulse(cap),
    .o_capture_held(caph), .o_crc_reset(crst), .o_crc_error(cerr),
    .o_clk_switch(sw), .o_clk_freq_sel(fsel), .o_restore_pulse(rest),
    .o_shutdown_active(shd), .o_word_aligned(alg),
    .o_readback_recalc(rcl), .o_warm_boot(wb), .o_watchdog_reload(wdr),
    .o_frame_location(floc), .o_port_bottom(pb), .o_security_level(sec),
    .o_readback_allowed(rba), .o_write_allowed(wra),
    .o_config_port_active(cpa), .o_user_io_tristate_n(utn),
    .o_user_pullup_off(puo), .o_no_fallback_on_fail(nfb),
    .o_parallel_abort_disable(pad), .o_lut_readback_mask_n(lmn),
    .o_aes_unit_on(aes), .o_thermal_shutoff_enable(thm));
  ccc_crc_model host_u (.i_clk(clk), .i_rst(rst), .i_wr(wr), .i_addr(addr),
    .i_wdata(wd), .i_crc_reset(crst), .o_crc(crc));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg

  task automatic cmd(input logic [4:0] c);
    wreg(ADDR_CMD, {27'h000_0000, c});
  endtask : cmd

  task automatic rreg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : rreg

  task automatic t_reset;
    logic [31:0] v;
    rreg(ADDR_CONTROL_ZERO_REG, v);
    check(v, CONTROL_ZERO_REG_RESET, "control reset value");
    check({hn, alg}, 32'h0000_0002, "hold and alignment at reset");
    cmd(CODE_WARMBOOT);
    check(pv, 32'h0000_0000, "command taken before alignment");
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    #1;
    check(alg, 1'b1, "alignment after sync");
  endtask : t_reset

  task automatic t_pulses;
    logic [4:0] codes [8];
    codes = '{CODE_MFW, CODE_CAPTURE, CODE_CRCRST, CODE_SWITCH,
              CODE_RESTORE, CODE_WARMBOOT, CODE_WDRELOAD, CODE_RECALC};
    for (int i = 0; i < 8; i++) begin
      cmd(codes[i]);
      check(pv, 32'h0000_0080 >> i, "command pulse");
    end
    check(caph, 1'b1, "capture held");
    wreg(ADDR_FAR, 32'h0012_3456);
    check(pv, 32'h0000_0001, "frame location rerun");
    check(floc, 32'h0012_3456, "frame location value");
    cmd(CODE_CAPCLR);
    check(caph, 1'b0, "capture cleared");
    wreg(ADDR_CMD, 32'h0000_002F);
    check(pv, 32'h0000_0000, "upper bits set");
    @(posedge clk);
    rben <= 1'b0;
    cmd(CODE_RECALC);
    check(pv, 32'h0000_0000, "recalc while disabled");
    @(posedge clk);
    rben <= 1'b1;
  endtask : t_pulses

  task automatic t_arming;
    cmd(CODE_WRITE_FRAMES_CMD);
    check({wa, ra}, 32'h0000_0002, "write armed");
    cmd(CODE_NULL);
    check({wa, ra}, 32'h0000_0002, "null keeps arm");
    cmd(CODE_READ_FRAMES_CMD);
    check({wa, ra}, 32'h0000_0001, "read armed");
    cmd(CODE_ISOLATE);
    check(hn, 1'b0, "interconnect isolated");
    cmd(CODE_RELEASE);
    check(hn, 1'b1, "interconnect released");
    wreg(ADDR_OPTION_REG_ZERO, 32'h0054_0000);
    cmd(CODE_SWITCH);
    check(fsel, 32'h0000_002A, "frequency select");
  endtask : t_arming

  task automatic t_control_zero_reg;
    logic [31:0] v;
    wreg(ADDR_MASK, 32'h0000_0001);
    wreg(ADDR_CONTROL_ZERO_REG, 32'h0000_0000);
    rreg(ADDR_CONTROL_ZERO_REG, v);
    check(v, 32'h0000_0100, "masked write");
    check(utn, 1'b0, "user io tristated");
    @(posedge clk);
    ctsn <= 1'b0;
    done <= 1'b1;
    step();
    step();
    check(puo, 1'b1, "pull-ups off");
    wreg(ADDR_MASK, 32'hFFFF_FFFF);
    wreg(ADDR_CONTROL_ZERO_REG, 32'hFFFF_FFFF);
    rreg(ADDR_CONTROL_ZERO_REG, v);
    check(v, CONTROL_ZERO_REG_WRITABLE, "full write");
    check({pb, sec, nfb, pad, lmn, aes, cpa}, 32'h0000_00FF, "fields");
    check({rba, wra, thm}, 32'h0000_0001, "no access");
    cmd(CODE_WRITE_FRAMES_CMD);
    check(wa, 1'b0, "write arm refused");
    wreg(ADDR_CONTROL_ZERO_REG, 32'h0000_0011);
    step();
    check({pb, rba, wra, cpa}, 32'h0000_0002, "readback blocked");
    cmd(CODE_READ_FRAMES_CMD);
    check(ra, 1'b0, "read arm refused");
    cmd(CODE_WRITE_FRAMES_CMD);
    check(wa, 1'b1, "write arm allowed");
  endtask : t_control_zero_reg

  task automatic t_crc_flow;
    int seen;
    seen = 0;
    cmd(CODE_SHUTDOWN);
    wreg(ADDR_CRC, ~crc);
    check({cerr, shd}, 32'h0000_0002, "bad checksum");
    cmd(CODE_START);
    wreg(ADDR_CRC, crc);
    check({cerr, shd, sgo}, 32'h0000_0002, "good checksum");
    cmd(CODE_DESYNC);
    check(alg, 1'b0, "alignment dropped");
    repeat (4) begin
      if (sgo === 1'b1) seen++;
      step();
    end
    check(seen, 32'h0000_0001, "startup launched once");
    cmd(CODE_WARMBOOT);
    check(pv, 32'h0000_0000, "ignored after desync");
  endtask : t_crc_flow

  task automatic tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pulses();
    t_arming();
    t_control_zero_reg();
    t_crc_flow();
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : testbench
